// *** core/mdshp_host_port.sv ***
// host port control of the 32-channel dac with sample-and-hold mode
//
// Contract
// - five-bit parallel channel address picks one of 32 channels, top line is msb.
// - in parallel mode the simultaneous-acquire input makes all 32 channels acquire.
// - one pin is parallel chip select, active low, and serial frame sync.
// - offset-select high sends a parallel access to the offset channel instead.
// - serial input bits are stable at and sampled on the falling serial clock edge.
// - readback bits shift out on rising serial clock edges, valid at next falling.
// - interface-select low uses the parallel port, high uses the serial port.
// - busy output is low for a whole acquisition, high again once finished.
// - with track held high a channel acquires as soon as it is addressed.
// - with track held low the analog input goes straight to the output stage.
// - acquisition of the addressed channel begins on the rising track edge.
// - a track low pulse of 50 to 150 ns restores the power-on state.
// - upper address, acquire-all, write, offset-select, interface-select pins default low.
// - lowest address, serial clock, serial data and track pins default high.
// - after power-on or reset every code register, offset channel included, is zero.
`timescale 1ns/100ps
`include "mdshp_regs.svh"
module mdshp_host_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic [`MDSHP_ADDR_W-1:0] channelSelectLines,
  input wire logic acquireAllIn,
  input wire logic csSyncN,
  input wire logic writeN,
  input wire logic offsetSelect,
  input wire logic interfaceTypePick,
  input wire logic trackN,
  input wire logic sclk,
  input wire logic serialDataIn,
  output logic serialDataOut,
  input wire logic [`MDSHP_CODE_W-1:0] adcCode,
  output logic busyN,
  output logic vinPassThrough,
  output logic [`MDSHP_ADDR_W-1:0] activeChannel,
  output logic [`MDSHP_NUM_CH*`MDSHP_CODE_W-1:0] channelCodes,
  output logic [`MDSHP_CODE_W-1:0] offsetCode
);

  ////////////////////////////////////////////////////////////////////////////
  // serial side
  logic [`MDSHP_FRAME_BITS-1:0] frameWord;
  logic frameDone;
  logic [`MDSHP_CODE_W-1:0] rbWord_reg, rbWord_next;

  mdshp_serial_link serialLink (
    .sclk(sclk),
    .csSyncN(csSyncN),
    .serialDataIn(serialDataIn),
    .rbWord(rbWord_reg),
    .frameWord(frameWord),
    .frameDone(frameDone),
    .serialDataOut(serialDataOut)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, reset to the pulled level of each pin
  logic [`MDSHP_PIN_W-1:0] pinRaw, pinMeta_reg, pinSync_reg, pinPrev_reg;

  assign pinRaw = {frameDone, trackN, interfaceTypePick, offsetSelect, writeN, csSyncN,
                   acquireAllIn, channelSelectLines};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinMeta_reg <= `MDSHP_PIN_RESET;
      pinSync_reg <= `MDSHP_PIN_RESET;
      pinPrev_reg <= `MDSHP_PIN_RESET;
    end else if (clkEn) begin
      pinMeta_reg <= pinRaw;
      pinSync_reg <= pinMeta_reg;
      pinPrev_reg <= pinSync_reg;
    end
  end

  logic serialMode, trackHigh, trackRise, strobeNow, strobeWas, parEvent, calRise, serEvent;
  mdshp_pkg::mdshp_addr_t pinAddr;

  assign serialMode = pinSync_reg[`MDSHP_P_IFSEL];
  assign pinAddr = pinSync_reg[`MDSHP_P_ADDR_MSB:`MDSHP_P_ADDR_LSB];
  assign trackHigh = pinSync_reg[`MDSHP_P_TRACK];
  assign trackRise = trackHigh & ~pinPrev_reg[`MDSHP_P_TRACK];
  assign strobeNow = ~pinSync_reg[`MDSHP_P_CS] & ~pinSync_reg[`MDSHP_P_WR];
  assign strobeWas = ~pinPrev_reg[`MDSHP_P_CS] & ~pinPrev_reg[`MDSHP_P_WR];
  assign parEvent = ~serialMode & strobeNow & ~strobeWas;
  assign calRise = ~serialMode & pinSync_reg[`MDSHP_P_CAL] & ~pinPrev_reg[`MDSHP_P_CAL];
  assign serEvent = serialMode & pinSync_reg[`MDSHP_P_FDONE] & ~pinPrev_reg[`MDSHP_P_FDONE];

  ////////////////////////////////////////////////////////////////////////////
  // decode of one address event from either port
  logic reqAcq, reqAll, reqOffs, reqWrite, reqRead;
  mdshp_pkg::mdshp_addr_t reqCh;
  mdshp_pkg::mdshp_code_t reqCode;

  always_comb begin
    reqAcq = 1'b0;
    reqAll = 1'b0;
    reqOffs = 1'b0;
    reqWrite = 1'b0;
    reqRead = 1'b0;
    reqCh = pinAddr;
    reqCode = frameWord[`MDSHP_F_CODE_MSB:`MDSHP_F_CODE_LSB];
    if (calRise) begin
      reqAcq = 1'b1;
      reqAll = 1'b1;
    end else if (parEvent) begin
      reqAcq = 1'b1;
      reqOffs = pinSync_reg[`MDSHP_P_OFFS];
    end else if (serEvent) begin
      reqCh = frameWord[`MDSHP_F_ADDR_MSB:`MDSHP_F_ADDR_LSB];
      reqOffs = frameWord[`MDSHP_F_OFFS];
      if (frameWord[`MDSHP_F_RD]) begin
        reqRead = 1'b1;
      end else if (frameWord[`MDSHP_F_SHA]) begin
        reqAcq = 1'b1;
      end else begin
        reqWrite = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acquisition sequencer and reset-pulse timing on the track pin
  mdshp_pkg::mdshp_state_e state_reg, state_next;
  mdshp_pkg::mdshp_cnt_t acqCnt_reg, acqCnt_next, lowCnt_reg, lowCnt_next;
  mdshp_pkg::mdshp_addr_t acqCh_reg, acqCh_next;
  logic acqAll_reg, acqAll_next, acqOffs_reg, acqOffs_next;
  logic pend_reg, pend_next, softReset, acqDone;

  // saturating low-time count, wider than the longest reset window
  always_comb begin
    lowCnt_next = lowCnt_reg;
    if (trackHigh) begin
      lowCnt_next = '0;
    end else if (lowCnt_reg != '1) begin
      lowCnt_next = lowCnt_reg + 1'b1;
    end
  end

  assign softReset = trackRise && lowCnt_reg >= `MDSHP_CNT_W'(`MDSHP_RST_MIN_CYC) &&
                     lowCnt_reg <= `MDSHP_CNT_W'(`MDSHP_RST_MAX_CYC);
  assign acqDone = state_reg == mdshp_pkg::ST_ACQ && acqCnt_reg == `MDSHP_CNT_W'(`MDSHP_ACQ_CYC - 1);

  always_comb begin
    state_next = state_reg;
    acqCnt_next = acqCnt_reg;
    acqCh_next = acqCh_reg;
    acqAll_next = acqAll_reg;
    acqOffs_next = acqOffs_reg;
    pend_next = pend_reg;
    case (state_reg)
      mdshp_pkg::ST_IDLE: begin
        // new addresses while busy are dropped, so only idle takes them
        if (reqAcq) begin
          acqCh_next = reqCh;
          acqAll_next = reqAll;
          acqOffs_next = reqOffs;
          if (trackHigh) begin
            state_next = mdshp_pkg::ST_ACQ;
            acqCnt_next = '0;
            pend_next = 1'b0;
          end else begin
            pend_next = 1'b1;
          end
        end else if (pend_reg && trackRise) begin
          state_next = mdshp_pkg::ST_ACQ;
          acqCnt_next = '0;
          pend_next = 1'b0;
        end
      end
      mdshp_pkg::ST_ACQ: begin
        acqCnt_next = acqCnt_reg + 1'b1;
        if (acqDone) begin
          state_next = mdshp_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = mdshp_pkg::ST_IDLE;
      end
    endcase
    if (softReset) begin
      state_next = mdshp_pkg::ST_IDLE;
      pend_next = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= mdshp_pkg::ST_IDLE;
      acqCnt_reg <= '0;
      acqCh_reg <= '0;
      acqAll_reg <= 1'b0;
      acqOffs_reg <= 1'b0;
      pend_reg <= 1'b0;
      lowCnt_reg <= '0;
    end else if (clkEn) begin
      state_reg <= state_next;
      acqCnt_reg <= acqCnt_next;
      acqCh_reg <= acqCh_next;
      acqAll_reg <= acqAll_next;
      acqOffs_reg <= acqOffs_next;
      pend_reg <= pend_next;
      lowCnt_reg <= lowCnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // code registers, one per channel plus the offset channel
  mdshp_pkg::mdshp_code_t code_reg [`MDSHP_NUM_CH];
  mdshp_pkg::mdshp_code_t code_next [`MDSHP_NUM_CH];
  mdshp_pkg::mdshp_code_t offs_reg, offs_next;
  logic writeOk;

  assign writeOk = reqWrite && state_reg == mdshp_pkg::ST_IDLE;

  genvar gi;
  generate
    for (gi = 0; gi < `MDSHP_NUM_CH; gi++) begin : chLoop
      always_comb begin
        code_next[gi] = code_reg[gi];
        if (softReset) begin
          code_next[gi] = `MDSHP_CODE_RESET;
        end else if (acqDone && !acqOffs_reg && (acqAll_reg || acqCh_reg == gi)) begin
          code_next[gi] = adcCode;
        end else if (writeOk && !reqOffs && reqCh == gi) begin
          code_next[gi] = reqCode;
        end
      end

      always_ff @(posedge sys_clk) begin
        if (rst) begin
          code_reg[gi] <= `MDSHP_CODE_RESET;
        end else if (clkEn) begin
          code_reg[gi] <= code_next[gi];
        end
      end

      assign channelCodes[gi*`MDSHP_CODE_W +: `MDSHP_CODE_W] = code_reg[gi];
    end
  endgenerate

  always_comb begin
    offs_next = offs_reg;
    rbWord_next = rbWord_reg;
    if (softReset) begin
      offs_next = `MDSHP_CODE_RESET;
      rbWord_next = `MDSHP_CODE_RESET;
    end else begin
      if (acqDone && acqOffs_reg) begin
        offs_next = adcCode;
      end else if (writeOk && reqOffs) begin
        offs_next = reqCode;
      end
      // readback word is staged here and shifted out during the next frame
      if (reqRead) begin
        rbWord_next = reqOffs ? offs_reg : code_reg[reqCh];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic passThrough_reg, passThrough_next;
  mdshp_pkg::mdshp_addr_t active_reg, active_next;

  always_comb begin
    passThrough_next = ~trackHigh;
    active_next = active_reg;
    if (softReset) begin
      active_next = '0;
    end else if (reqAcq && state_reg == mdshp_pkg::ST_IDLE) begin
      active_next = reqCh;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      offs_reg <= `MDSHP_CODE_RESET;
      rbWord_reg <= `MDSHP_CODE_RESET;
      passThrough_reg <= 1'b0;
      active_reg <= '0;
    end else if (clkEn) begin
      offs_reg <= offs_next;
      rbWord_reg <= rbWord_next;
      passThrough_reg <= passThrough_next;
      active_reg <= active_next;
    end
  end

  assign offsetCode = offs_reg;
  assign busyN = state_reg != mdshp_pkg::ST_ACQ;
  assign vinPassThrough = passThrough_reg;
  assign activeChannel = active_reg;

endmodule

// *** inc/mdshp_regs.svh ***
// constants for the multichannel dac / sha host port
`ifndef MDSHP_REGS_SVH
`define MDSHP_REGS_SVH

`define MDSHP_NUM_CH 32
`define MDSHP_ADDR_W 5
`define MDSHP_CODE_W 14
`define MDSHP_CODE_RESET 14'h0000

// serial frame layout, first bit shifted in lands in the top position
`define MDSHP_FRAME_BITS 22
`define MDSHP_FCNT_W 5
`define MDSHP_F_RD 21
`define MDSHP_F_SHA 20
`define MDSHP_F_OFFS 19
`define MDSHP_F_ADDR_MSB 18
`define MDSHP_F_ADDR_LSB 14
`define MDSHP_F_CODE_MSB 13
`define MDSHP_F_CODE_LSB 0

// synchronised pin vector positions
`define MDSHP_PIN_W 12
`define MDSHP_P_ADDR_MSB 4
`define MDSHP_P_ADDR_LSB 0
`define MDSHP_P_CAL 5
`define MDSHP_P_CS 6
`define MDSHP_P_WR 7
`define MDSHP_P_OFFS 8
`define MDSHP_P_IFSEL 9
`define MDSHP_P_TRACK 10
`define MDSHP_P_FDONE 11
// pull defaults: lowest address line, chip select and track high, rest low
`define MDSHP_PIN_RESET 12'h441

// timing
`define MDSHP_CLK_PERIOD_PS 5000
`define MDSHP_RST_MIN_NS 50
`define MDSHP_RST_MAX_NS 150
`define MDSHP_ACQ_NS 1000
`define MDSHP_SCLK_DAC_MAX_MHZ 14
`define MDSHP_SCLK_SHA_MAX_MHZ 20
`define MDSHP_RST_MIN_CYC ((`MDSHP_RST_MIN_NS * 1000 + `MDSHP_CLK_PERIOD_PS - 1) / `MDSHP_CLK_PERIOD_PS)
`define MDSHP_RST_MAX_CYC ((`MDSHP_RST_MAX_NS * 1000) / `MDSHP_CLK_PERIOD_PS)
`define MDSHP_ACQ_CYC ((`MDSHP_ACQ_NS * 1000) / `MDSHP_CLK_PERIOD_PS)
`define MDSHP_CNT_W 8

`endif

// *** inc/mdshp_pkg.sv ***
// types shared by the host port files
package mdshp_pkg;
  typedef enum logic {ST_IDLE, ST_ACQ} mdshp_state_e;
  typedef logic [13:0] mdshp_code_t;
  typedef logic [4:0] mdshp_addr_t;
  typedef logic [7:0] mdshp_cnt_t;
endpackage

// *** core/mdshp_serial_link.sv ***
// serial link end, runs on the host serial clock
`timescale 1ns/100ps
`include "mdshp_regs.svh"
module mdshp_serial_link (
  input wire logic sclk,
  input wire logic csSyncN,
  input wire logic serialDataIn,
  input wire logic [`MDSHP_CODE_W-1:0] rbWord,
  output logic [`MDSHP_FRAME_BITS-1:0] frameWord,
  output logic frameDone,
  output logic serialDataOut
);

  ////////////////////////////////////////////////////////////////////////////
  logic [`MDSHP_FCNT_W-1:0] bitCnt_reg, bitCnt_next;
  logic [`MDSHP_FRAME_BITS-1:0] shiftIn_reg, shiftIn_next;
  logic [`MDSHP_FRAME_BITS-1:0] frameWord_reg, frameWord_next;
  logic frameDone_reg, frameDone_next;
  logic [`MDSHP_CODE_W-1:0] outShift_reg, outShift_next;
  logic outLoaded_reg, outLoaded_next;

  always_comb begin
    bitCnt_next = bitCnt_reg;
    shiftIn_next = {shiftIn_reg[`MDSHP_FRAME_BITS-2:0], serialDataIn};
    frameWord_next = frameWord_reg;
    frameDone_next = frameDone_reg;
    if (!frameDone_reg) begin
      bitCnt_next = bitCnt_reg + 1'b1;
      if (bitCnt_reg == `MDSHP_FCNT_W'(`MDSHP_FRAME_BITS - 1)) begin
        frameWord_next = shiftIn_next;
        frameDone_next = 1'b1;
      end
    end
  end

  // clock stops between frames, so the frame's own select ends it
  always_ff @(negedge sclk or posedge csSyncN) begin
    if (csSyncN) begin
      bitCnt_reg <= '0;
      frameDone_reg <= 1'b0;
    end else begin
      bitCnt_reg <= bitCnt_next;
      frameDone_reg <= frameDone_next;
    end
  end

  // data only, qualified by frameDone in the other domain
  always_ff @(negedge sclk) begin
    shiftIn_reg <= shiftIn_next;
    frameWord_reg <= frameWord_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // rbWord is quasi-static: written one whole frame before it is shifted out
  always_comb begin
    outLoaded_next = 1'b1;
    if (outLoaded_reg) begin
      outShift_next = {outShift_reg[`MDSHP_CODE_W-2:0], 1'b0};
    end else begin
      outShift_next = rbWord;
    end
  end

  always_ff @(posedge sclk or posedge csSyncN) begin
    if (csSyncN) begin
      outLoaded_reg <= 1'b0;
      outShift_reg <= `MDSHP_CODE_RESET;
    end else begin
      outLoaded_reg <= outLoaded_next;
      outShift_reg <= outShift_next;
    end
  end

  assign frameWord = frameWord_reg;
  assign frameDone = frameDone_reg;
  assign serialDataOut = outShift_reg[`MDSHP_CODE_W-1];

endmodule

// *** verification/mdshp_host_port_checker.sv ***
// assertion checker for the host port, bound to the top module
`timescale 1ns/100ps
`include "mdshp_regs.svh"
module mdshp_host_port_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic acquireAllIn,
  input wire logic csSyncN,
  input wire logic writeN,
  input wire logic interfaceTypePick,
  input wire logic trackN,
  input wire logic serialDataOut,
  input wire logic busyN,
  input wire logic vinPassThrough,
  input wire logic [`MDSHP_ADDR_W-1:0] activeChannel,
  input wire logic [`MDSHP_NUM_CH*`MDSHP_CODE_W-1:0] channelCodes,
  input wire logic [`MDSHP_CODE_W-1:0] offsetCode
);
  // counted, since a repetition of 200 would be far too slow to unroll
  mdshp_pkg::mdshp_cnt_t lowCnt_reg;
  mdshp_pkg::mdshp_cnt_t lowCnt_next;
  always_comb begin
    lowCnt_next = (rst || busyN) ? 8'h00 : lowCnt_reg + 8'h01;
  end
  always_ff @(posedge sys_clk) begin
    lowCnt_reg <= lowCnt_next;
  end
  default clocking @(posedge sys_clk); endclocking
  ////////////////////////////////////////////////////////////
  busy_len_a: assert property (disable iff (rst) !busyN |-> lowCnt_reg < 8'hC8)
    else $error("busy held low too long");
  reset_state_a: assert property (rst |=> busyN && channelCodes == '0 && offsetCode == '0 && activeChannel == '0)
    else $error("state not cleared by reset");
  dout_idle_a: assert property (disable iff (rst) csSyncN [*2] |-> !serialDataOut)
    else $error("readback driven outside a frame");
  pass_on_a: assert property (disable iff (rst) !trackN [*5] |-> vinPassThrough)
    else $error("no pass through while track low");
  pass_off_a: assert property (disable iff (rst) trackN [*5] |-> !vinPassThrough)
    else $error("pass through while track high");
  acq_all_a: assert property (disable iff (rst)
    $rose(acquireAllIn) && busyN && trackN && !interfaceTypePick |-> ##[2:6] !busyN)
    else $error("acquire-all did not start acquisition");
  strobe_start_a: assert property (disable iff (rst) $fell(writeN) && !csSyncN && busyN && trackN
    && !acquireAllIn && !interfaceTypePick |-> ##[2:6] !busyN)
    else $error("parallel strobe did not start acquisition");
  code_hold_a: assert property (disable iff (rst)
    !interfaceTypePick && $changed(channelCodes) |-> $rose(busyN) || channelCodes == '0)
    else $error("channel codes changed outside acquisition end");
  cover property ($fell(busyN));
  cover property ($rose(vinPassThrough));
  cover property (interfaceTypePick && $changed(channelCodes));
endmodule

bind mdshp_host_port mdshp_host_port_checker chk_i (
  .sys_clk(sys_clk),
  .rst(rst),
  .acquireAllIn(acquireAllIn),
  .csSyncN(csSyncN),
  .writeN(writeN),
  .interfaceTypePick(interfaceTypePick),
  .trackN(trackN),
  .serialDataOut(serialDataOut),
  .busyN(busyN),
  .vinPassThrough(vinPassThrough),
  .activeChannel(activeChannel),
  .channelCodes(channelCodes),
  .offsetCode(offsetCode)
);

// *** verification/mdshp_host_model.sv ***
// host model: sends serial frames and captures readback
`timescale 1ns/100ps
module mdshp_host_model (
  output logic sclk,
  output logic hostCsN,
  output logic serialDataIn,
  input wire logic serialDataOut
);
  // 75 ns period keeps the bit rate under the dac-mode ceiling
  localparam real HALF = 37.5;
  initial begin
    sclk = 1'b1;
    hostCsN = 1'b1;
    serialDataIn = 1'b1;
  end
  task automatic frame(input logic [21:0] w, output logic [13:0] rd);
    logic [21:0] cap;
    cap = '0;
    hostCsN = 1'b0;
    for (int i = 21; i >= 0; i--) begin
      serialDataIn = w[i];
      #HALF sclk = 1'b0;
      cap = {cap[20:0], serialDataOut};
      #HALF sclk = 1'b1;
    end
    #30 hostCsN = 1'b1;
    // released line floats to its pulled-up level
    serialDataIn = 1'b1;
    #30 rd = cap[20:7];
  endtask
endmodule

// *** verification/mdshp_host_port_tb_top.sv ***
// testbench for the host port: parallel rows, then track, serial and soft-reset cases
`timescale 1ns/100ps
`include "mdshp_regs.svh"
module mdshp_host_port_tb_top;
  typedef struct {
    logic [4:0] a;
    logic o;
    logic al;
    logic [13:0] c;
  } mdshp_row_s;
  mdshp_row_s rows[4] = '{'{5'h00, 1'b0, 1'b0, 14'h1234}, '{5'h1F, 1'b0, 1'b0, 14'h3FFF},
    '{5'h0A, 1'b1, 1'b0, 14'h0ABC}, '{5'h05, 1'b0, 1'b1, 14'h2222}};
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] chSel = 5'h01;
  logic acqAll = 1'b0;
  logic parCsN = 1'b1;
  logic writeN = 1'b1;
  logic offSel = 1'b0;
  logic pick = 1'b0;
  logic trackN = 1'b1;
  logic [13:0] adc = 14'h0000;
  logic [13:0] rd;
  wire logic sclk, hostCsN, sdi, sdo, busyN, vinPass;
  wire logic csN = parCsN & hostCsN;
  wire logic [4:0] actCh;
  wire logic [447:0] codes;
  wire logic [13:0] offCode;
  int mismatches = 0;
  int nChecks = 0;
  int n;
  always #2.5 sys_clk = ~sys_clk;
  mdshp_host_model host (.sclk(sclk), .hostCsN(hostCsN), .serialDataIn(sdi), .serialDataOut(sdo));
  mdshp_host_port dut (.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .channelSelectLines(chSel),
    .acquireAllIn(acqAll), .csSyncN(csN), .writeN(writeN), .offsetSelect(offSel), .interfaceTypePick(pick),
    .trackN(trackN), .sclk(sclk), .serialDataIn(sdi), .serialDataOut(sdo), .adcCode(adc), .busyN(busyN),
    .vinPassThrough(vinPass), .activeChannel(actCh), .channelCodes(codes), .offsetCode(offCode));
  ////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acq(input logic [4:0] a, input logic o, input logic al, input logic [13:0] c, output int cnt);
    adc = c;
    chSel = a;
    offSel = o;
    if (al) acqAll = 1'b1;
    else begin
      parCsN = 1'b0;
      writeN = 1'b0;
    end
    cnt = 0;
    for (int i = 0; i < 50 && busyN === 1'b1; i++) tick(1);
    while (busyN === 1'b0 && cnt < 400) begin
      cnt++;
      tick(1);
    end
    parCsN = 1'b1;
    writeN = 1'b1;
    acqAll = 1'b0;
    // strobes must stay released a few cycles before the next one
    tick(4);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #150000;
    mismatches++;
    test_done;
  end
  initial begin
    tick(3);
    rst = 1'b0;
    tick(5);
    chk("busy", 14'h0001, 14'(busyN));
    chk("ch0", 14'h0000, codes[13:0]);
    chk("offset", 14'h0000, offCode);
    $display("reset test done");
    foreach (rows[i]) begin
      acq(rows[i].a, rows[i].o, rows[i].al, rows[i].c, n);
      chk("busy cycles", 14'(`MDSHP_ACQ_CYC), 14'(n));
      if (rows[i].al) begin
        chk("ch0", rows[i].c, codes[13:0]);
        chk("ch31", rows[i].c, codes[447:434]);
        chk("offset kept", 14'h0ABC, offCode);
      end else if (rows[i].o) chk("offset", rows[i].c, offCode);
      else chk("channel", rows[i].c, codes[rows[i].a*14 +: 14]);
    end
    $display("parallel rows done");
    trackN = 1'b0;
    tick(35);
    chk("pass through", 14'h0001, 14'(vinPass));
    chSel = 5'h03;
    parCsN = 1'b0;
    writeN = 1'b0;
    tick(10);
    chk("busy before track rise", 14'h0001, 14'(busyN));
    trackN = 1'b1;
    acq(5'h03, 1'b0, 1'b0, 14'h0333, n);
    chk("ch3", 14'h0333, codes[55:42]);
    $display("track test done");
    adc = 14'h0888;
    chSel = 5'h08;
    parCsN = 1'b0;
    writeN = 1'b0;
    tick(10);
    parCsN = 1'b1;
    writeN = 1'b1;
    tick(4);
    chSel = 5'h09;
    parCsN = 1'b0;
    writeN = 1'b0;
    tick(300);
    parCsN = 1'b1;
    writeN = 1'b1;
    tick(10);
    chk("ch8", 14'h0888, codes[125:112]);
    chk("ch9 refused", 14'h2222, codes[139:126]);
    chk("active ch8", 14'h0008, 14'(actCh));
    $display("refusal test done");
    pick = 1'b1;
    tick(5);
    host.frame({3'b000, 5'h14, 14'h1357}, rd);
    tick(10);
    chk("serial write", 14'h1357, codes[293:280]);
    chSel = 5'h15;
    parCsN = 1'b0;
    writeN = 1'b0;
    tick(20);
    chk("strobe in serial mode", 14'h0001, 14'(busyN));
    parCsN = 1'b1;
    writeN = 1'b1;
    tick(5);
    host.frame({3'b100, 5'h14, 14'h0000}, rd);
    host.frame({3'b000, 5'h16, 14'h0005}, rd);
    chk("readback", 14'h1357, rd);
    tick(10);
    chk("serial write 2", 14'h0005, codes[321:308]);
    adc = 14'h0246;
    host.frame({3'b010, 5'h02, 14'h0000}, rd);
    tick(210);
    chk("serial acquire", 14'h0246, codes[41:28]);
    chk("serial acq ch", 14'h0002, 14'(actCh));
    pick = 1'b0;
    tick(5);
    $display("serial test done");
    trackN = 1'b0;
    tick(20);
    trackN = 1'b1;
    tick(10);
    chk("ch31 after pulse", 14'h0000, codes[447:434]);
    chk("offset after pulse", 14'h0000, offCode);
    chk("busy after pulse", 14'h0001, 14'(busyN));
    chk("active after pulse", 14'h0000, 14'(actCh));
    $display("soft reset test done");
    test_done;
  end
endmodule
